// >>> rtl/srag_top.sv
/*
 * soft counter reset sequencer and agc gain preload.
 * assumes one clock ref_clk_i; the sample and processing clocks and
 * the second sync arrive as pins and are synchronised before use.
 */
`include "srag_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module srag_top #(
	parameter int ACC_W     = 32,   // agc loop accumulator width
	parameter int IRQ_LEVEL = 4     // fifo depth raising the interrupt
) (
	input  wire logic               ref_clk_i,
	input  wire logic               rstn_i,
	input  wire logic [7:0]         addr_i,
	input  wire logic [31:0]        wdata_i,
	input  wire logic               wr_i,
	input  wire logic               rd_i,
	output logic      [31:0]        rdata_o,
	input  wire logic               input_sample_clock_i,
	input  wire logic               processing_clock_i,
	input  wire logic               second_sync_input_i,
	input  wire logic [ACC_W-1:0]   agc_limiter_i,
	input  wire logic               fifo_push_i,
	input  wire logic               fifo_pop_i,
	output logic                    fe_reset_o,
	output logic                    be_reset_o,
	output var srag_pkg::srag_init_type be_init_o,
	output var srag_pkg::srag_fifo_type fifo_o,
	output logic                    fifo_rd_strobe_o,
	output logic                    fifo_interrupt_o,
	output logic                    gain_preload_strobe_o,
	output logic      [ACC_W-1:0]   agc_acc_o,
	output logic      [3:0]         agc_exponent_o,
	output logic      [8:0]         agc_mantissa_o
);

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] pin_meta_r;   // first stage, read only by second
	logic [2:0] pin_sync_r;   // settled copy
	logic [2:0] pin_prev_r;   // for rising edge detect
	logic [2:0] pin_rise;     // one-cycle rising edge per pin

	// two flops per pin; the clocks may be asynchronous to us
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_meta_r <= 3'h0;
			pin_sync_r <= 3'h0;
			pin_prev_r <= 3'h0;
		end else begin
			pin_meta_r <= {second_sync_input_i, processing_clock_i,
				input_sample_clock_i};
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	assign pin_rise = pin_sync_r & ~pin_prev_r;

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	logic        reset_wr;     // write to counter reset word
	logic        gain_wr;      // write to gain load word
	logic [31:0] cfg_r;        // nco select and agc inhibit bits
	logic [31:0] status;       // live state for readback
	logic [31:0] rd_val;       // read mux
	logic [31:0] rdata_r;      // read data, one cycle after strobe

	// reset word ignores the written value: the write itself is the command
	assign reset_wr = wr_i && (addr_i == `SRAG_OFF_CNT_RESET);
	assign gain_wr  = wr_i && (addr_i == `SRAG_OFF_GAIN_LOAD);

	// config register, unused bits stay zero
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg_r <= `SRAG_CFG_RST;
		end else if (wr_i && addr_i == `SRAG_OFF_CONFIG) begin
			cfg_r <= wdata_i & `SRAG_CFG_MASK;
		end
	end

	// ----------------------------------------
	// front-end and back-end reset pulses
	// ----------------------------------------
	logic [1:0] pulse_act;     // 0 front end, 1 back end
	logic [1:0] pulse_start;   // pulse begins or restarts

	// channel 0 counts sample clock edges, channel 1 processing edges
	for (genvar c = 0; c < 2; c++) begin : g_pulse
		srag_pkg::srag_seq_type seq_r;
		srag_pkg::srag_seq_type seq_nxt;
		logic [3:0] cnt_r;     // periods left in the pulse
		logic [3:0] cnt_nxt;
		logic       rearm_r;   // write seen while pulsing
		logic       rearm_nxt;
		logic       act_r;     // registered pulse level
		logic [3:0] span_r;    // helper: edges seen while active

		// the write is armed per domain and fires on that domain's edge
		always_comb begin
			seq_nxt   = seq_r;
			cnt_nxt   = cnt_r;
			rearm_nxt = 1'b0;
			case (seq_r)
				srag_pkg::SEQ_IDLE: begin
					if (reset_wr) begin
						seq_nxt = srag_pkg::SEQ_ARMED;
					end
				end
				srag_pkg::SEQ_ARMED: begin
					if (pin_rise[c]) begin
						seq_nxt = srag_pkg::SEQ_PULSE;
						cnt_nxt = `SRAG_PULSE_PERIODS;
					end
				end
				srag_pkg::SEQ_PULSE: begin
					// set wins over the clear of the restart flag
					rearm_nxt = reset_wr | (rearm_r & ~pin_rise[c]);
					if (pin_rise[c]) begin
						if (rearm_r) begin
							cnt_nxt = `SRAG_PULSE_PERIODS;
						end else if (cnt_r == 4'h1) begin
							// ten edges gone: end, or arm again
							cnt_nxt   = 4'h0;
							seq_nxt   = reset_wr ? srag_pkg::SEQ_ARMED
								: srag_pkg::SEQ_IDLE;
							rearm_nxt = 1'b0;
						end else begin
							cnt_nxt = cnt_r - 4'h1;
						end
					end
				end
				default: begin
					seq_nxt = srag_pkg::SEQ_IDLE;
				end
			endcase
		end

		// sequencer state
		always_ff @(posedge ref_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				seq_r   <= srag_pkg::SEQ_IDLE;
				cnt_r   <= 4'h0;
				rearm_r <= 1'b0;
				act_r   <= 1'b0;
			end else begin
				seq_r   <= seq_nxt;
				cnt_r   <= cnt_nxt;
				rearm_r <= rearm_nxt;
				act_r   <= (seq_nxt == srag_pkg::SEQ_PULSE);
			end
		end

		assign pulse_start[c] = pin_rise[c] &&
			(seq_r == srag_pkg::SEQ_ARMED ||
			(seq_r == srag_pkg::SEQ_PULSE && rearm_r));
		assign pulse_act[c] = act_r;

		// helper counting domain edges inside one pulse
		always_ff @(posedge ref_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				span_r <= 4'h0;
			end else if (pulse_start[c]) begin
				span_r <= 4'h0;
			end else if (act_r && pin_rise[c]) begin
				span_r <= span_r + 4'h1;
			end
		end

		chk_pulse_width: assert property (
			$fell(act_r) |-> span_r == `SRAG_PULSE_PERIODS)
			else $error("reset pulse is not ten domain periods");

		chk_pulse_start: assert property (
			pulse_start[c] |=> act_r [*2])
			else $error("reset pulse did not follow its domain edge");
	end

	assign fe_reset_o = pulse_act[0];
	assign be_reset_o = pulse_act[1];

	// ----------------------------------------
	// back-end stage initialise strobes
	// ----------------------------------------
	srag_pkg::srag_init_type init_r;
	logic                    be_hold;   // back-end pulse is high after this edge

	// same term that sets the pulse, so strobes and fifo hold line up with it
	assign be_hold = (g_pulse[1].seq_nxt == srag_pkg::SEQ_PULSE);

	// every back-end stage but the nco feedback, cleared only with its select bit set, is held at its start point for the pulse
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			init_r <= '0;
		end else begin
			init_r.nco_fb_clear    <= be_hold && cfg_r[`SRAG_CFG_NCO_SEL];
			init_r.nco_insert_init <= be_hold;
			init_r.disc_ptr_init   <= be_hold;
			init_r.cordic_abort    <= be_hold;
			init_r.fifo_ctl_init   <= be_hold;
			init_r.snapshot_init   <= be_hold;
			init_r.serial_init     <= be_hold;
		end
	end

	assign be_init_o = init_r;

	chk_nco_keep: assert property (
		!cfg_r[`SRAG_CFG_NCO_SEL] && $stable(cfg_r) |=> !init_r.nco_fb_clear)
		else $error("nco feedback cleared with select low");

	chk_init_follow: assert property (
		be_reset_o |-> init_r.cordic_abort && init_r.serial_init
			&& init_r.snapshot_init && init_r.disc_ptr_init
			&& init_r.nco_insert_init && init_r.fifo_ctl_init)
		else $error("stage init strobe missing during back-end reset");

	// ----------------------------------------
	// output fifo controller
	// ----------------------------------------
	srag_pkg::srag_fifo_type fifo_r;
	srag_pkg::srag_fifo_type fifo_nxt;
	logic do_push;   // accepted write into fifo
	logic do_pop;    // accepted read from fifo
	logic rd_stb_r;  // read strobe to the output
	logic irq_r;     // depth reached the interrupt level

	// read slot seven, write slot zero, empty
	localparam srag_pkg::srag_fifo_type FIFO_RST = {`SRAG_FIFO_RD_RST,
		`SRAG_FIFO_WR_RST, 4'h0, 1'b1, 1'b0};

	assign do_push = fifo_push_i && !fifo_r.full;
	assign do_pop  = fifo_pop_i && !fifo_r.empty;

	// read pointer names the last slot read, so it starts at seven
	always_comb begin
		fifo_nxt = fifo_r;
		if (do_push) begin
			fifo_nxt.wr_ptr = fifo_r.wr_ptr + 3'h1;
		end
		if (do_pop) begin
			fifo_nxt.rd_ptr = fifo_r.rd_ptr + 3'h1;
		end
		if (do_push && !do_pop) begin
			fifo_nxt.depth = fifo_r.depth + 4'h1;
		end else if (do_pop && !do_push) begin
			fifo_nxt.depth = fifo_r.depth - 4'h1;
		end
		fifo_nxt.empty = (fifo_nxt.depth == 4'h0);
		fifo_nxt.full  = (fifo_nxt.depth == `SRAG_FIFO_FULL);
	end

	// back-end reset overrides any traffic from the pulse's first cycle on,
	// so no stale interrupt shows while the reset output is high
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fifo_r   <= FIFO_RST;
			rd_stb_r <= 1'b0;
			irq_r    <= 1'b0;
		end else if (be_hold) begin
			fifo_r   <= FIFO_RST;
			rd_stb_r <= 1'b0;
			irq_r    <= 1'b0;
		end else begin
			fifo_r   <= fifo_nxt;
			rd_stb_r <= do_pop;
			irq_r    <= (fifo_nxt.depth >= 4'(IRQ_LEVEL));
		end
	end

	assign fifo_o           = fifo_r;
	assign fifo_rd_strobe_o = rd_stb_r;
	assign fifo_interrupt_o = irq_r;

	chk_fifo_init: assert property (
		be_reset_o |-> fifo_r.rd_ptr == 3'h7 && fifo_r.wr_ptr == 3'h0
			&& fifo_r.empty && !fifo_r.full && fifo_r.depth == 4'h0)
		else $error("fifo not at reset state after back-end reset");

	chk_fifo_quiet: assert property (
		be_reset_o |-> !fifo_rd_strobe_o && !fifo_interrupt_o)
		else $error("fifo strobe or interrupt during reset");

	// ----------------------------------------
	// agc gain preload and accumulator
	// ----------------------------------------
	logic [`SRAG_GAIN_W-1:0] preload_r; // master register copy
	logic             load_pend_r;     // load waiting for a proc edge
	logic             sync_pend_r;     // sync clear waiting likewise
	logic             load_go;         // apply the preload now
	logic             clr_go;          // clear the accumulator now
	logic             load_stb_r;      // registered load strobe
	logic [ACC_W-1:0] acc_r;           // loop filter accumulator

	// only the low sixteen bits are trusted from the host
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			preload_r <= 11'h000;
		end else if (gain_wr) begin
			preload_r <= wdata_i[`SRAG_GAIN_HI:`SRAG_GAIN_LO];
		end
	end

	// pending flags: a new event wins over the clear at the edge
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			load_pend_r <= 1'b0;
			sync_pend_r <= 1'b0;
		end else begin
			load_pend_r <= gain_wr | (load_pend_r & ~pin_rise[`SRAG_PIN_PROC]);
			sync_pend_r <= pin_rise[`SRAG_PIN_SYNC] |
				(sync_pend_r & ~pin_rise[`SRAG_PIN_PROC]);
		end
	end

	assign load_go = load_pend_r && pin_rise[`SRAG_PIN_PROC];
	// reset write clears unless inhibited; second sync clears even when inhibited, unless a preload applies at the same edge
	assign clr_go  = (pulse_start[1] && !cfg_r[`SRAG_CFG_AGC_INH]) ||
		(sync_pend_r && pin_rise[`SRAG_PIN_PROC]);

	// mux: limiter normally, master register only on the load strobe
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			acc_r      <= '0;
			load_stb_r <= 1'b0;
		end else begin
			load_stb_r <= load_go;
			if (load_go) begin
				acc_r <= {preload_r, {(ACC_W-`SRAG_GAIN_W){1'b0}}};
			end else if (clr_go) begin
				acc_r <= '0;
			end else if (pin_rise[`SRAG_PIN_PROC]) begin
				acc_r <= agc_limiter_i;
			end
		end
	end

	assign gain_preload_strobe_o = load_stb_r;
	assign agc_acc_o      = acc_r;
	assign agc_exponent_o = acc_r[ACC_W-1 -: `SRAG_EXP_W];
	// implied leading 01 ahead of the seven fraction bits
	assign agc_mantissa_o = {`SRAG_MANT_LEAD,
		acc_r[ACC_W-1-`SRAG_EXP_W -: `SRAG_MANT_W]};

	chk_load_msb: assert property (
		load_go |=> agc_exponent_o == $past(preload_r[10:7])
			&& agc_mantissa_o[6:0] == $past(preload_r[6:0]))
		else $error("preload not in accumulator msbs");

	chk_mant_weight: assert property (
		agc_mantissa_o[8:7] == 2'b01)
		else $error("mantissa lead bits not 01");

	chk_mux_limiter: assert property (
		pin_rise[`SRAG_PIN_PROC] && !load_go && !clr_go
			|=> acc_r == $past(agc_limiter_i))
		else $error("accumulator did not take the limiter");

	chk_clear_inhibit: assert property (
		pulse_start[1] && !load_go |=>
			(acc_r == '0) || $past(cfg_r[`SRAG_CFG_AGC_INH]))
		else $error("accumulator not cleared by reset write");

	chk_load_sync: assert property (
		gain_wr && !load_pend_r ##1 !pin_rise[`SRAG_PIN_PROC] |=> !load_stb_r)
		else $error("gain load applied off a processing edge");

	chk_sync_clear: assert property (
		sync_pend_r && pin_rise[`SRAG_PIN_PROC] && !load_go |=> acc_r == '0)
		else $error("second sync did not clear the accumulator");

	// ----------------------------------------
	// status and read port
	// ----------------------------------------
	// live sequencer and fifo state for software
	always_comb begin
		status = 32'h0000_0000;
		status[`SRAG_ST_FE]   = fe_reset_o;
		status[`SRAG_ST_BE]   = be_reset_o;
		status[`SRAG_ST_LOAD] = load_pend_r;
		status[`SRAG_ST_SYNC] = sync_pend_r;
		status[`SRAG_ST_DEPTH_LO +: 4] = fifo_r.depth;
		status[`SRAG_ST_EMPTY] = fifo_r.empty;
		status[`SRAG_ST_FULL]  = fifo_r.full;
	end

	// write-only and unmapped words read zero
	always_comb begin
		case (addr_i)
			`SRAG_OFF_CONFIG: rd_val = cfg_r;
			`SRAG_OFF_STATUS: rd_val = status;
			default:          rd_val = 32'h0000_0000;
		endcase
	end

	// data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= rd_i ? rd_val : 32'h0000_0000;
		end
	end

	assign rdata_o = rdata_r;

	chk_reset_arm: assert property (
		reset_wr |=> g_pulse[1].seq_r != srag_pkg::SEQ_IDLE)
		else $error("reset write did not arm back-end sequence");

endmodule

`default_nettype wire

// >>> rtl/srag_regs.svh
/*
 * register offsets, field positions, reset values and counts for the
 * soft reset and agc gain load block.
 * assumes a 32-bit word-aligned plain register port.
 */
`ifndef SRAG_REGS_SVH
`define SRAG_REGS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SRAG_OFF_CNT_RESET   8'h00
`define SRAG_OFF_GAIN_LOAD   8'h04
`define SRAG_OFF_CONFIG      8'h08
`define SRAG_OFF_STATUS      8'h0c

// ----------------------------------------
// config fields and reset value
// ----------------------------------------
`define SRAG_CFG_NCO_SEL     20
`define SRAG_CFG_AGC_INH     15
`define SRAG_CFG_MASK        32'h0010_8000
`define SRAG_CFG_RST         32'h0000_0000

// ----------------------------------------
// gain load word layout
// ----------------------------------------
`define SRAG_GAIN_HI         15
`define SRAG_GAIN_LO         5
`define SRAG_GAIN_W          11
`define SRAG_EXP_W           4
`define SRAG_MANT_W          7
`define SRAG_MANT_LEAD       2'h1

// ----------------------------------------
// status fields
// ----------------------------------------
`define SRAG_ST_FE           0
`define SRAG_ST_BE           1
`define SRAG_ST_LOAD         2
`define SRAG_ST_SYNC         3
`define SRAG_ST_DEPTH_LO     4
`define SRAG_ST_EMPTY        8
`define SRAG_ST_FULL         9

// ----------------------------------------
// pin indices, counts and fifo reset values
// ----------------------------------------
`define SRAG_PIN_ISC         0
`define SRAG_PIN_PROC        1
`define SRAG_PIN_SYNC        2
`define SRAG_PULSE_PERIODS   4'ha
`define SRAG_FIFO_RD_RST     3'h7
`define SRAG_FIFO_WR_RST     3'h0
`define SRAG_FIFO_FULL       4'h8

`endif

// >>> rtl/srag_pkg.sv
/*
 * types shared by the soft reset and agc gain load block.
 * assumes nothing beyond a systemverilog compiler.
 */
package srag_pkg;

	// ----------------------------------------
	// reset pulse sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_ARMED,
		SEQ_PULSE
	} srag_seq_type;

	// ----------------------------------------
	// per-stage initialise strobes (back end)
	// ----------------------------------------
	typedef struct packed {
		logic nco_fb_clear;
		logic nco_insert_init;
		logic disc_ptr_init;
		logic cordic_abort;
		logic fifo_ctl_init;
		logic snapshot_init;
		logic serial_init;
	} srag_init_type;

	// ----------------------------------------
	// output fifo controller state
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] rd_ptr;
		logic [2:0] wr_ptr;
		logic [3:0] depth;
		logic       empty;
		logic       full;
	} srag_fifo_type;

endpackage

// >>> verif/srag_host_model.sv
/*
 * host processor model: writes and reads control words over the
 * plain register port of the soft reset and agc gain load block.
 * assumes read data stand only in the cycle after the read strobe.
 */
`include "srag_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module srag_host_model (
	input  wire logic        ref_clk_i,
	output var  logic [7:0]  addr_o,
	output var  logic [31:0] wdata_o,
	output var  logic        wr_o,
	output var  logic        rd_o,
	input  wire logic [31:0] rdata_i
);
	// ----------------------------------------
	// idle bus at time zero
	// ----------------------------------------
	initial begin
		addr_o  = 8'h00;
		wdata_o = 32'h0000_0000;
		wr_o    = 1'b0;
		rd_o    = 1'b0;
	end

	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	// one-cycle write; released lines flip so a stale value never lingers
	task automatic write_word(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_o  <= a;
		// gain word: upper half left as junk, only the low half is valid
		wdata_o <= (a == `SRAG_OFF_GAIN_LOAD) ? {~d[31:16], d[15:0]} : d;
		wr_o    <= 1'b1;
		@(posedge ref_clk_i);
		wr_o    <= 1'b0;
		addr_o  <= ~a;
		wdata_o <= ~d;
	endtask

	// one-cycle read; data taken in the cycle after the strobe
	task automatic read_word(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		addr_o <= a;
		rd_o   <= 1'b1;
		@(posedge ref_clk_i);
		rd_o   <= 1'b0;
		addr_o <= ~a;
		#1;
		d = rdata_i;
	endtask
endmodule
`default_nettype wire

// >>> verif/testbench.sv
/*
 * self-checking bench for the soft reset and agc gain load block.
 * assumes the host model above and slow pin clocks made here.
 */
`include "srag_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
	// ----------------------------------------
	// pin clock periods in ref cycles, limiter value
	// ----------------------------------------
	localparam int          ISC_P  = 6;
	localparam int          PROC_P = 8;
	localparam logic [31:0] LIM    = 32'h1357_9bdf;

	logic                   ref_clk_i;
	logic                   rstn_i = 1'b0;     // active low
	logic [7:0]             addr;
	logic [31:0]            wdata;
	logic                   wr;
	logic                   rd;
	logic [31:0]            rdata;
	logic                   isc    = 1'b0;     // sample clock pin
	logic                   proc   = 1'b0;     // processing clock pin
	logic                   push   = 1'b0;
	logic                   pop    = 1'b0;
	logic                   sync   = 1'b0;     // second sync pin
	logic                   fe_rst;
	logic                   be_rst;
	srag_pkg::srag_init_type be_init;
	srag_pkg::srag_fifo_type fifo;
	logic                   rd_stb;
	logic                   irq;
	logic                   ld_stb;
	logic [31:0]            acc;
	logic [3:0]             expo;
	logic [8:0]             mant;
	int                     miscompares = 0;
	int                     checks      = 0;
	int                     cyc         = 0;

	srag_top i_srag_top (
		.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .input_sample_clock_i(isc),
		.processing_clock_i(proc), .second_sync_input_i(sync), .agc_limiter_i(LIM),
		.fifo_push_i(push), .fifo_pop_i(pop), .fe_reset_o(fe_rst), .be_reset_o(be_rst),
		.be_init_o(be_init), .fifo_o(fifo), .fifo_rd_strobe_o(rd_stb),
		.fifo_interrupt_o(irq), .gain_preload_strobe_o(ld_stb), .agc_acc_o(acc),
		.agc_exponent_o(expo), .agc_mantissa_o(mant)
	);

	srag_host_model i_srag_host_model (
		.ref_clk_i(ref_clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
		.rd_o(rd), .rdata_i(rdata)
	);

	// ----------------------------------------
	// clocks: ref clock plus free-running pin clocks
	// ----------------------------------------
	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	// pin clocks derived from ref cycles, unrelated to each other
	always @(posedge ref_clk_i) begin
		cyc  <= cyc + 1;
		isc  <= (cyc % ISC_P) < (ISC_P / 2);
		proc <= (cyc % PROC_P) < (PROC_P / 2);
	end

	// ----------------------------------------
	// compare and verdict
	// ----------------------------------------
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string w);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: %s got %h expected %h", $time, w, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp, input string w);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: %s got %b expected %b", $time, w, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// pulse helpers: sample just after each edge
	// ----------------------------------------
	// bounded wait for a reset pulse to rise
	task automatic wait_high(input logic be);
		for (int i = 0; i < 40; i++) begin
			@(posedge ref_clk_i);
			#1;
			if ((be ? be_rst : fe_rst) === 1'b1) break;
		end
	endtask

	// ref cycles that the pulse stays high, counting the first one
	task automatic count_high(input logic be, output int n);
		n = 1;
		for (int i = 0; i < 200; i++) begin
			@(posedge ref_clk_i);
			#1;
			if ((be ? be_rst : fe_rst) !== 1'b1) break;
			n++;
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// reset values and register access kinds
	task automatic t_regs();
		logic [31:0] got;
		#1;
		check_word(32'(fifo), 32'h0000_0e02, "fifo reset");
		check_bit(irq | rd_stb, 1'b0, "irq or strobe");
		i_srag_host_model.read_word(`SRAG_OFF_CONFIG, got);
		check_word(got, 32'h0000_0000, "config reset");
		i_srag_host_model.write_word(`SRAG_OFF_CONFIG, 32'hffff_ffff);
		i_srag_host_model.write_word(8'hf0, 32'h0000_0000);
		i_srag_host_model.read_word(`SRAG_OFF_CONFIG, got);
		check_word(got, 32'h0010_8000, "config mask");
		i_srag_host_model.read_word(`SRAG_OFF_CNT_RESET, got);
		check_word(got, 32'h0000_0000, "reset word");
		i_srag_host_model.read_word(8'hf0, got);
		check_word(got, 32'h0000_0000, "unmapped");
		i_srag_host_model.read_word(`SRAG_OFF_STATUS, got);
		check_word(got, 32'h0000_0100, "status");
		$display("test regs done");
	endtask

	// full fifo, then a counter reset write; widths and stage strobes
	task automatic t_reset(input logic sel, input logic inh);
		int nf;
		int nb;
		i_srag_host_model.write_word(`SRAG_OFF_CONFIG, {11'h0, sel, 4'h0, inh, 15'h0});
		@(posedge ref_clk_i);
		push <= 1'b1;
		repeat (9) @(posedge ref_clk_i);
		push <= 1'b0;
		#1;
		check_bit(fifo.full & irq, 1'b1, "fifo full");
		@(posedge ref_clk_i);
		pop <= 1'b1;
		@(posedge ref_clk_i);
		pop <= 1'b0;
		#1;
		check_bit(rd_stb, 1'b1, "pop strobe");
		i_srag_host_model.write_word(`SRAG_OFF_CNT_RESET, 32'hdead_beef);
		fork
			begin
				wait_high(1'b0);
				count_high(1'b0, nf);
			end
			begin
				wait_high(1'b1);
				check_word(32'(be_init), 32'({sel, 6'h3f}), "init");
				check_word(acc, inh ? LIM : 32'h0000_0000, "acc clear");
				check_word(32'(fifo), 32'h0000_0e02, "fifo init");
				check_bit(irq | rd_stb, 1'b0, "irq drop");
				count_high(1'b1, nb);
			end
		join
		check_word(32'(nf), 32'(10 * ISC_P), "fe width");
		check_word(32'(nb), 32'(10 * PROC_P), "be width");
		$display("test reset done");
	endtask

	// gain preload and return to the limiter
	task automatic t_gain();
		i_srag_host_model.write_word(`SRAG_OFF_GAIN_LOAD, 32'h0000_a5e0);
		for (int i = 0; i < PROC_P + 6; i++) begin
			@(posedge ref_clk_i);
			#1;
			if (ld_stb === 1'b1) break;
		end
		check_bit(ld_stb, 1'b1, "load strobe");
		check_word(acc, 32'ha5e0_0000, "acc load");
		check_word(32'(expo), 32'h0000_000a, "exponent");
		check_word(32'(mant), 32'h0000_00af, "mantissa");
		@(posedge ref_clk_i);
		#1;
		check_bit(ld_stb, 1'b0, "strobe width");
		repeat (2 * PROC_P) @(posedge ref_clk_i);
		#1;
		check_word(acc, LIM, "limiter");
		$display("test gain done");
	endtask

	// second reset write inside the front-end pulse: reload on the next edge,
	// so the pulse spans eleven sample periods in all
	task automatic t_rearm();
		int n;
		i_srag_host_model.write_word(`SRAG_OFF_CNT_RESET, 32'h0000_0000);
		wait_high(1'b0);
		i_srag_host_model.write_word(`SRAG_OFF_CNT_RESET, 32'h0000_0001);
		count_high(1'b0, n);
		check_word(32'(n + 2), 32'(11 * ISC_P), "fe rearm");
		count_high(1'b1, n);
		$display("test rearm done");
	endtask

	// second sync clears the accumulator even with the inhibit bit set
	task automatic t_sync();
		@(posedge ref_clk_i);
		sync <= 1'b1;
		for (int i = 0; i < PROC_P + 8; i++) begin
			@(posedge ref_clk_i);
			#1;
			if (acc === 32'h0000_0000) break;
		end
		check_word(acc, 32'h0000_0000, "sync clear");
		@(posedge ref_clk_i);
		sync <= 1'b0;
		repeat (2 * PROC_P) @(posedge ref_clk_i);
		#1;
		check_word(acc, LIM, "sync limiter");
		$display("test sync done");
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		t_regs();
		t_reset(1'b1, 1'b0);
		t_reset(1'b0, 1'b1);
		t_rearm();
		t_gain();
		t_sync();
		print_verdict();
	end

	// whole run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		miscompares++;
		$display("Error at %0t: watchdog expired", $time);
		print_verdict();
	end
endmodule
`default_nettype wire
